// ### hw/adc_offset_and_mode_config_regs.sv
// Config register bank with AXI4-Lite access and per-channel offset correction
// Notes on behaviour
// RL1: With correction on, each output converges to midcode plus its pedestal.
// RL2: Pedestal field bits 7..4 is a signed offset, -8 to +7 codes.
// RL3: Pedestal is two's complement: 0111 +7, 0000 zero, 1111 -1, 1000 -8.
// RL4: Channel A pedestal lives at index BFh, channel B at C1h.
// RL5: Hold bit 7 of CFh freezes the estimate; the last one keeps applying.
// RL6: Software keeps correction enabled for the hold bit to mean anything.
// RL7: Loop time constant in sample cycles comes from CFh bits 5..2.
// RL8: Software sets channel A fast input bit above 200 MHz inputs.
// RL9: Low-speed master bit 4 of EFh off forces both channels out of low speed.
// RL10: F2h bit 3 enables channel A low speed, master enable first.
// RL11: DBh bit 0 enables channel B low speed, master enable first.
// RL12: F1h bits 1..0 enable swing control only at 11; 01 and 10 unused.
// RL13: Above 160 MSPS software sets all six performance tuning bits.
// RL14: All registers reset to 00h; unassigned bits are written as zero.
// RL15: Correction runs only while bit 5 of 3Dh is set.
// RL16: Digital functions, correction included, need bit 3 of 42h set.
// RL17: Setting changes take effect only on a sample boundary; the mode outputs follow register writes without waiting for one.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module adc_offset_and_mode_config_regs import adc_cfg_pkg::*; #(
  parameter int DW = DATA_W
) (
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter samples, offset binary, same clock
  input wire logic sampleValid,
  input wire logic [DW-1:0] chanASample,
  input wire logic [DW-1:0] chanBSample,
  output logic [DW-1:0] chanAOut,
  output logic [DW-1:0] chanBOut,
  output logic chanOutValid,
  // Mode levels to the analog side
  output logic slowModeA,
  output logic slowModeB,
  output logic swingCtrlOn,
  output logic fastInputA,
  output logic [5:0] perfTuneBits
);
  typedef struct packed {
    logic [NREG-1:0][REG_W-1:0] regs;
    logic awHeld;
    logic [IDX_W-1:0] awIdx;
    logic awAlign;
    logic wHeld;
    logic [REG_W-1:0] wByte;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic slowA;
    logic slowB;
    logic swing;
  } bank_state_type;

  bank_state_type st_r, st_nxt;
  logic wrHit, rdHit, rdOk;
  logic [3:0] wrSlot, rdSlot;
  logic [DW-1:0] outA, outB;
  logic validA, validB;

  // Index to storage slot; shared by read and write decode
  function automatic logic [4:0] slot_of(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_PERF_TUNE_A: slot_of = {1'b1, 4'(S_PERF_A)};
      IDX_OFFSET_LOOP_EN: slot_of = {1'b1, 4'(S_LOOP_EN)};
      IDX_DIGITAL_EN: slot_of = {1'b1, 4'(S_DIG_EN)};
      IDX_FAST_INPUT_A: slot_of = {1'b1, 4'(S_FAST_A)};
      IDX_CHAN_A_PEDESTAL_CFG: slot_of = {1'b1, 4'(S_PED_A)}; // [RL4]
      IDX_CHAN_B_PEDESTAL_CFG: slot_of = {1'b1, 4'(S_PED_B)}; // [RL4]
      IDX_OFFSET_LOOP_CFG: slot_of = {1'b1, 4'(S_LOOP_CFG)};
      IDX_PERF_TUNE_B: slot_of = {1'b1, 4'(S_PERF_B)};
      IDX_PERF_TUNE_C: slot_of = {1'b1, 4'(S_PERF_C)};
      IDX_PERF_TUNE_D_SLOW_B: slot_of = {1'b1, 4'(S_PERF_D)};
      IDX_SLOW_MODE_MASTER: slot_of = {1'b1, 4'(S_SLOW_M)};
      IDX_SWING_CTRL_ENABLE: slot_of = {1'b1, 4'(S_SWING)};
      IDX_SLOW_MODE_CHAN_A: slot_of = {1'b1, 4'(S_SLOW_A)};
      default: slot_of = 5'h00;
    endcase
  endfunction

  // Write decode from the held address, read decode from the live read address
  always_comb begin
    {wrHit, wrSlot} = slot_of(st_r.awIdx);
    {rdHit, rdSlot} = slot_of(s_axi_araddr[IDX_W+1:2]);
    // Bits above the index must be zero, else the map would repeat every 1 KB
    rdOk = rdHit && (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[ADDR_W-1:IDX_W+2] == '0);
  end

  // Write channels accept only while their own word is not held and no response is pending; reads only while no read data is pending
  assign s_axi_awready = !st_r.awHeld && !st_r.bValid;
  assign s_axi_wready = !st_r.wHeld && !st_r.bValid;
  assign s_axi_arready = !st_r.rValid;

  // Bus side: capture, commit, respond
  always_comb begin
    st_nxt = st_r;
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awIdx = s_axi_awaddr[IDX_W+1:2];
      // Aligned and inside the map; anything else is answered with an error
      st_nxt.awAlign = (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr[ADDR_W-1:IDX_W+2] == '0);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wByte = s_axi_wdata[REG_W-1:0];
      st_nxt.wLane0 = s_axi_wstrb[0];
    end
    if (st_r.awHeld && st_r.wHeld) begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp = (wrHit && st_r.awAlign) ? RESP_OKAY : RESP_SLVERR;
      // Only assigned bits store; everything else reads back zero
      if (wrHit && st_r.awAlign && st_r.wLane0) begin
        st_nxt.regs[wrSlot] = st_r.wByte & REG_MASK[wrSlot]; // [RL14]
      end
    end
    if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rData = rdOk ? {24'h000000, st_r.regs[rdSlot]} : 32'h00000000;
      st_nxt.rResp = rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end
    // Low-speed gating: master bit overrides both channel bits
    st_nxt.slowA = st_r.regs[S_SLOW_M][SLOW_MASTER_BIT] && st_r.regs[S_SLOW_A][SLOW_A_BIT]; // [RL9] [RL10]
    st_nxt.slowB = st_r.regs[S_SLOW_M][SLOW_MASTER_BIT] && st_r.regs[S_PERF_D][SLOW_B_BIT]; // [RL9] [RL11]
    // Unused codes 01 and 10 are treated as off
    st_nxt.swing = (st_r.regs[S_SWING][SWING_LSB +: SWING_W] == SWING_ON); // [RL12]
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.regs <= {NREG{REG_RESET}}; // [RL14]
    end else begin
      st_r <= st_nxt;
    end
  end

  // Channel A correction
  offset_loop #(.DW(DW), .FW(FRAC_W)) u_loop_a (
    .mclk(mclk),
    .rst(rst),
    .sampleValid(sampleValid),
    .sampleIn(chanASample),
    .loopOn(st_r.regs[S_LOOP_EN][LOOP_ON_BIT]), // [RL15]
    .digitalOn(st_r.regs[S_DIG_EN][DIG_EN_BIT]), // [RL16]
    .estHold(st_r.regs[S_LOOP_CFG][HOLD_BIT]), // [RL5]
    .tau(st_r.regs[S_LOOP_CFG][TAU_LSB +: TAU_W]), // [RL7]
    .pedestal(st_r.regs[S_PED_A][PED_LSB +: PED_W]), // [RL2]
    .sampleOut(outA),
    .sampleOutValid(validA)
  );

  // Channel B correction shares loop settings, keeps its own pedestal
  offset_loop #(.DW(DW), .FW(FRAC_W)) u_loop_b (
    .mclk(mclk),
    .rst(rst),
    .sampleValid(sampleValid),
    .sampleIn(chanBSample),
    .loopOn(st_r.regs[S_LOOP_EN][LOOP_ON_BIT]),
    .digitalOn(st_r.regs[S_DIG_EN][DIG_EN_BIT]),
    .estHold(st_r.regs[S_LOOP_CFG][HOLD_BIT]),
    .tau(st_r.regs[S_LOOP_CFG][TAU_LSB +: TAU_W]),
    .pedestal(st_r.regs[S_PED_B][PED_LSB +: PED_W]), // [RL4]
    .sampleOut(outB),
    .sampleOutValid(validB)
  );

  // Outputs, all from flip-flops
  assign s_axi_bvalid = st_r.bValid;
  assign s_axi_bresp = st_r.bResp;
  assign s_axi_rvalid = st_r.rValid;
  assign s_axi_rdata = st_r.rData;
  assign s_axi_rresp = st_r.rResp;
  assign chanAOut = outA;
  assign chanBOut = outB;
  assign chanOutValid = validA && validB;
  assign slowModeA = st_r.slowA;
  assign slowModeB = st_r.slowB;
  assign swingCtrlOn = st_r.swing;
  assign fastInputA = st_r.regs[S_FAST_A][FAST_A_BIT];
  // Order: bit 0 is tuning bit 3 through bit 5 is tuning bit 8
  assign perfTuneBits = {st_r.regs[S_PERF_D][PERF8_BIT], st_r.regs[S_PERF_C][PERF7_BIT],
    st_r.regs[S_PERF_C][PERF6_BIT], st_r.regs[S_PERF_B][PERF5_BIT],
    st_r.regs[S_PERF_B][PERF4_BIT], st_r.regs[S_PERF_A][PERF3_BIT]};
endmodule

// ### hw/adc_cfg_pkg.sv
// Register map, field layout and loop constants for the converter config tail
package adc_cfg_pkg;
  localparam int DATA_W = 12;
  localparam int REG_W = 8;
  localparam int NREG = 13;
  localparam int IDX_W = 8;
  localparam int ADDR_W = 12;
  localparam int FRAC_W = 16;
  // Register indices as printed; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PERF_TUNE_A = 8'h02;
  localparam logic [IDX_W-1:0] IDX_OFFSET_LOOP_EN = 8'h3d;
  localparam logic [IDX_W-1:0] IDX_DIGITAL_EN = 8'h42;
  localparam logic [IDX_W-1:0] IDX_FAST_INPUT_A = 8'h58;
  localparam logic [IDX_W-1:0] IDX_CHAN_A_PEDESTAL_CFG = 8'hbf;
  localparam logic [IDX_W-1:0] IDX_CHAN_B_PEDESTAL_CFG = 8'hc1;
  localparam logic [IDX_W-1:0] IDX_OFFSET_LOOP_CFG = 8'hcf;
  localparam logic [IDX_W-1:0] IDX_PERF_TUNE_B = 8'hd5;
  localparam logic [IDX_W-1:0] IDX_PERF_TUNE_C = 8'hd7;
  localparam logic [IDX_W-1:0] IDX_PERF_TUNE_D_SLOW_B = 8'hdb;
  localparam logic [IDX_W-1:0] IDX_SLOW_MODE_MASTER = 8'hef;
  localparam logic [IDX_W-1:0] IDX_SWING_CTRL_ENABLE = 8'hf1;
  localparam logic [IDX_W-1:0] IDX_SLOW_MODE_CHAN_A = 8'hf2;
  // Storage slots
  localparam int S_PERF_A = 0;
  localparam int S_LOOP_EN = 1;
  localparam int S_DIG_EN = 2;
  localparam int S_FAST_A = 3;
  localparam int S_PED_A = 4;
  localparam int S_PED_B = 5;
  localparam int S_LOOP_CFG = 6;
  localparam int S_PERF_B = 7;
  localparam int S_PERF_C = 8;
  localparam int S_PERF_D = 9;
  localparam int S_SLOW_M = 10;
  localparam int S_SWING = 11;
  localparam int S_SLOW_A = 12;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  // Writable bits per slot; all other bits hold zero
  localparam logic [NREG-1:0][REG_W-1:0] REG_MASK = {
    8'h08, 8'h03, 8'h10, 8'h21, 8'h0c, 8'h18, 8'hbc, 8'hf0, 8'hf0, 8'h01, 8'h08, 8'h20, 8'h40};
  // Field positions
  localparam int PED_LSB = 4;
  localparam int PED_W = 4;
  localparam int HOLD_BIT = 7;
  localparam int TAU_LSB = 2;
  localparam int TAU_W = 4;
  localparam int LOOP_ON_BIT = 5;
  localparam int DIG_EN_BIT = 3;
  localparam int FAST_A_BIT = 0;
  localparam int SLOW_MASTER_BIT = 4;
  localparam int SLOW_A_BIT = 3;
  localparam int SLOW_B_BIT = 0;
  localparam int SWING_LSB = 0;
  localparam int SWING_W = 2;
  localparam logic [SWING_W-1:0] SWING_ON = 2'h3;
  localparam int PERF3_BIT = 6;
  localparam int PERF4_BIT = 4;
  localparam int PERF5_BIT = 3;
  localparam int PERF6_BIT = 3;
  localparam int PERF7_BIT = 2;
  localparam int PERF8_BIT = 5;
  localparam logic [DATA_W-1:0] MIDCODE = 12'h800;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### hw/offset_loop.sv
// One channel of offset estimation and pedestal correction
`timescale 1ns/1ps
module offset_loop import adc_cfg_pkg::*; #(
  parameter int DW = DATA_W,
  parameter int FW = FRAC_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sampleValid,
  input wire logic [DW-1:0] sampleIn,
  input wire logic loopOn,
  input wire logic digitalOn,
  input wire logic estHold,
  input wire logic [TAU_W-1:0] tau,
  input wire logic [PED_W-1:0] pedestal,
  output logic [DW-1:0] sampleOut,
  output logic sampleOutValid
);
  typedef struct packed {
    logic signed [DW+FW:0] acc;
    logic loopOn;
    logic digitalOn;
    logic hold;
    logic [TAU_W-1:0] tau;
    logic [PED_W-1:0] ped;
    logic [DW-1:0] out;
    logic outValid;
  } loop_state_type;

  loop_state_type st_r, st_nxt;
  logic signed [DW+1:0] centered, est, err, corr;
  logic signed [DW+FW:0] step;

  // Settings are sampled only on a sample strobe so no output mixes old and new
  always_comb begin
    st_nxt = st_r;
    centered = $signed({2'b00, sampleIn}) - $signed({2'b00, MIDCODE});
    est = (DW+2)'(st_r.acc >>> FW);
    err = centered - est;
    // Widen before shifting so the error bits are not lost off the top
    step = ((DW+FW+1)'(err) <<< FW) >>> st_r.tau;
    corr = $signed({2'b00, sampleIn}) - est + (DW+2)'($signed(st_r.ped)); // [RL1] [RL2] [RL3]
    st_nxt.outValid = sampleValid;
    if (sampleValid) begin
      st_nxt.loopOn = loopOn; // [RL17]
      st_nxt.digitalOn = digitalOn;
      st_nxt.hold = estHold;
      st_nxt.tau = tau;
      st_nxt.ped = pedestal;
      if (!(st_r.loopOn && st_r.digitalOn)) begin
        // Loop off: estimate restarts from zero on the next enable
        st_nxt.acc = '0; // [RL15] [RL16]
        st_nxt.out = sampleIn;
      end else begin
        if (!st_r.hold) begin
          st_nxt.acc = st_r.acc + step; // [RL5] [RL7]
        end
        // Saturate rather than wrap: a wrap would flip full scale to zero
        if (corr < 0) begin
          st_nxt.out = '0;
        end else if (corr > $signed({2'b00, {DW{1'b1}}})) begin
          st_nxt.out = '1;
        end else begin
          st_nxt.out = DW'(corr);
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sampleOut = st_r.out;
  assign sampleOutValid = st_r.outValid;
endmodule

// ### bench/adc_cfg_regs_asserts.sv
// Port-level checks for the config bank
`timescale 1ns/1ps
module adc_cfg_regs_asserts import adc_cfg_pkg::*; #(
  parameter int DW = DATA_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sampleValid,
  input wire logic [DW-1:0] chanAOut,
  input wire logic [DW-1:0] chanBOut,
  input wire logic chanOutValid,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Bus steps built from named handshakes
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_OUT_VALID: assert property (sampleValid |=> chanOutValid)
    else $error("no output strobe after sample");
  AST_OUT_QUIET: assert property (!sampleValid |=> !chanOutValid)
    else $error("output strobe without sample");
  AST_OUT_HOLD: assert property (!sampleValid |=> $stable(chanAOut) && $stable(chanBOut))
    else $error("outputs moved off a sample boundary");
  AST_WR_RESP: assert property (wrTaken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_WR_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_RD_RESP: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read data late");
  AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
endmodule
bind adc_offset_and_mode_config_regs adc_cfg_regs_asserts #(.DW(DW)) adc_cfg_regs_asserts_i (.mclk, .rst,
  .sampleValid, .chanAOut, .chanBOut, .chanOutValid, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// ### bench/testbench.sv
// Self-checking bench for the config bank and offset loop
`timescale 1ns/1ps
module testbench;
  import adc_cfg_pkg::*;
  logic mclk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, sampleValid = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [DATA_W-1:0] chanASample = 0, chanBSample = 0, chanAOut, chanBOut, tgt, d;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, chanOutValid;
  logic slowModeA, slowModeB, swingCtrlOn, fastInputA;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] perfTuneBits;
  logic [3:0] pedB;
  logic [DATA_W-1:0] dInv, tgtB;
  int n_errors = 0, n_tests = 0, cyc = 0;
  // Model: index, writable bits and content of each register
  logic [7:0] ix [13] = '{8'h02, 8'h3d, 8'h42, 8'h58, 8'hbf, 8'hc1, 8'hcf, 8'hd5, 8'hd7, 8'hdb, 8'hef, 8'hf1, 8'hf2};
  logic [7:0] mk [13] = '{8'h40, 8'h20, 8'h08, 8'h01, 8'hf0, 8'hf0, 8'hbc, 8'h18, 8'h0c, 8'h21, 8'h10, 8'h03, 8'h08};
  logic [7:0] mdl [13] = '{default: 8'h00};
  logic [3:0] pv [4] = '{4'h7, 4'h0, 4'hf, 4'h8};

  adc_offset_and_mode_config_regs adc_offset_and_mode_config_regs_i (.mclk, .rst, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sampleValid,
    .chanASample, .chanBSample, .chanAOut, .chanBOut, .chanOutValid, .slowModeA, .slowModeB, .swingCtrlOn,
    .fastInputA, .perfTuneBits);

  // Clock and reset
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 0;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // A hang counts as a mismatch
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Expected content and response; unmapped places answer with an error
  function automatic logic [7:0] look(input logic [7:0] i, output logic [1:0] r);
    look = 8'h00;
    r = RESP_SLVERR;
    foreach (ix[k]) if (ix[k] == i) begin
      look = mdl[k];
      r = RESP_OKAY;
    end
  endfunction

  // Handshakes are judged just after each edge, before the next one takes them
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    logic a, w, b;
    logic [1:0] r, e;
    @(posedge mclk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    b = 0;
    while (!b) begin
      #1;
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (a) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
      if (b) s_axi_bready <= 0;
    end
    // Let outputs launched at the answer edge settle before anyone looks
    #1;
    void'(look(i, e));
    foreach (ix[k]) if (ix[k] == i) mdl[k] = v & mk[k];
    chk(r, e);
  endtask

  task automatic rd(input logic [7:0] i);
    logic a, v;
    logic [31:0] q;
    logic [1:0] r, e;
    @(posedge mclk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    v = 0;
    while (!v) begin
      #1;
      a = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      q = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (a) s_axi_arvalid <= 0;
      if (v) s_axi_rready <= 0;
    end
    chk(q, look(i, e));
    chk(r, e);
  endtask

  task automatic modes;
    chk(slowModeA, mdl[10][4] & mdl[12][3]);
    chk(slowModeB, mdl[10][4] & mdl[9][0]);
    chk(swingCtrlOn, mdl[11][1:0] == 2'h3);
    chk(fastInputA, mdl[3][0]);
    chk(perfTuneBits, {mdl[9][5], mdl[8][2], mdl[8][3], mdl[7][3], mdl[7][4], mdl[0][6]});
  endtask

  task automatic smp(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    @(posedge mclk);
    sampleValid <= 1;
    chanASample <= a;
    chanBSample <= b;
    @(posedge mclk);
    sampleValid <= 0;
    #1;
  endtask

  // First strobe only captures settings, the rest must pass straight through
  task automatic bypass;
    smp(12'h000, 12'h000);
    repeat (6) begin
      d = $urandom;
      dInv = ~d;
      smp(d, dInv);
      chk(chanAOut, d);
      chk(chanBOut, dInv);
    end
  endtask

  initial begin
    void'($urandom(43));
    wait (!rst);
    foreach (ix[k]) rd(ix[k]);
    rd(8'h03);
    wr(8'h03, 8'hff);
    repeat (40) begin
      wr(ix[$urandom_range(12)], $urandom);
      rd(ix[$urandom_range(12)]);
      modes;
    end
    foreach (ix[k]) wr(ix[k], 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'hf1, c[7:0]);
      modes;
    end
    wr(8'hef, 8'h10);
    wr(8'hf2, 8'h08);
    wr(8'hdb, 8'h01);
    modes;
    wr(8'hef, 8'h00);
    modes;
    bypass;
    wr(8'h3d, 8'h20);
    bypass;
    wr(8'h42, 8'h08);
    // Every pedestal sign case, channel B on its own field
    foreach (pv[p]) begin
      wr(8'hbf, {pv[p], 4'h0});
      pedB = pv[p] + 4'h3;
      wr(8'hc1, {pedB, 4'h0});
      repeat (6) smp(MIDCODE + 12'h025, MIDCODE - 12'h015);
      tgt = MIDCODE + {{8{pv[p][3]}}, pv[p]};
      // Sign comes from the wrapped four-bit field, sum kept at output width
      tgtB = MIDCODE + {{8{pedB[3]}}, pedB};
      chk(chanAOut, tgt);
      chk(chanBOut, tgtB);
    end
    // Slow time constant cannot follow a step within three samples
    wr(8'hcf, 8'h0c);
    // One settled sample first, so the new constant is in force before the step
    smp(MIDCODE + 12'h025, MIDCODE);
    repeat (3) smp(MIDCODE + 12'h065, MIDCODE);
    chk(chanAOut !== tgt, 1);
    // Shift of 3: estimate 25h, 2Dh, 34h, so the third output sits 31h above target
    chk(chanAOut, tgt + 12'h031);
    wr(8'hcf, 8'h00);
    repeat (6) smp(MIDCODE + 12'h065, MIDCODE);
    chk(chanAOut, tgt);
    // Hold is written only while correction stays enabled
    wr(8'hcf, 8'h80);
    repeat (2) smp(MIDCODE + 12'h065, MIDCODE);
    repeat (3) smp(MIDCODE + 12'h079, MIDCODE);
    chk(chanAOut, tgt + 12'h014);
    wr(8'hcf, 8'h00);
    repeat (6) smp(MIDCODE + 12'h079, MIDCODE);
    chk(chanAOut, tgt);
    wr(8'h3d, 8'h00);
    bypass;
    test_done;
  end
endmodule
